// ==== src/pulk_pkg.sv ====
// Constants and state types for the power sequencer and memory lock
// Notes on behaviour
// (R1) At power-up hold internal reset with the sensor output at high impedance.
// (R2) Start the power-on release counter when supply crosses the reset rise threshold.
// (R3) Release reset only after release time elapsed and lockout exit threshold reached.
// (R4) Reassert reset, output high impedance, when supply falls to reset fall threshold.
// (R5) Supply below lockout entry threshold enters lockout with output forced to ground.
// (R6) Supply rising to the lockout exit threshold leaves the lockout state.
// (R7) Lockout engages only after the engage delay from the entry crossing.
// (R8) After exit crossing wait the disengage delay before releasing lockout, output valid.
// (R9) Every power-up applies the default lock blocking all register reads and writes.
// (R10) Default lock lifts only on the exact 30-bit code written to address 0x24.
// (R11) The unlock code is accepted only within 8 ms from power-up.
// (R12) A supply power cycle restores the default lock and discards earlier unlock.
// (R13) Permanent lock set and power cycled refuses every register read and write.
// (R14) Under permanent lock a correct code within the window does not unlock.
// (R15) Under permanent lock nothing can clear the permanent lock bit.
// (R16) Programmer should trim sensitivity before the zero-field level trim.
// (R17) The power-on release counter runs 64 us after the rise crossing.
// (R18) Engage counter runs 64 us; recovery above entry before the end cancels lockout.
// (R19) Disengage delay is 14 us, then the output returns to mid supply.
// (R20) Window expiry without valid code disables register access until next power-up.
// (R21) Threshold flags are synchronised; delay counters run on the clock, cleared by reset.
package pulk_pkg;

    // ==========================================================================
    // Timing
    localparam int CLK_MHZ                    = 125;
    localparam int RESET_RELEASE_TIME_US      = 64;
    localparam int LOCKOUT_ENGAGE_DELAY_US    = 64;
    localparam int LOCKOUT_DISENGAGE_DELAY_US = 14;
    localparam int UNLOCK_WINDOW_TIME_MS      = 8;
    localparam int US_PER_MS                  = 1000;
    localparam int RESET_RELEASE_CYC          = RESET_RELEASE_TIME_US * CLK_MHZ;
    localparam int LOCKOUT_ENGAGE_CYC         = LOCKOUT_ENGAGE_DELAY_US * CLK_MHZ;
    localparam int LOCKOUT_DISENGAGE_CYC      = LOCKOUT_DISENGAGE_DELAY_US * CLK_MHZ;
    localparam int UNLOCK_WINDOW_CYC          = UNLOCK_WINDOW_TIME_MS * US_PER_MS * CLK_MHZ;

    // ==========================================================================
    // Register access
    localparam int              ADDR_W                 = 8;
    localparam int              CODE_W                 = 30;
    localparam logic [ADDR_W-1:0] UNLOCK_CODE_ENTRY_ADDR = 8'h24;
    // Arbitrary neutral default for the customer unlock code
    localparam logic [CODE_W-1:0] UNLOCK_CODE_DEFAULT  = 30'h0ACE_1234;

    // ==========================================================================
    // Comparator flag positions
    localparam int CMP_N          = 4;
    localparam int CMP_RISE       = 0;
    localparam int CMP_FALL       = 1;
    localparam int CMP_EXIT       = 2;
    localparam int CMP_ENTRY      = 3;
    localparam logic [CMP_N-1:0] CMP_RESET_VAL = 4'h0;

    // ==========================================================================
    // Power sequencing states
    typedef enum logic [6:0] {
        PWR_OFF      = 7'h01,
        PWR_RELEASE  = 7'h02,
        PWR_ARMING   = 7'h04,
        PWR_RUN      = 7'h08,
        PWR_ENGAGING = 7'h10,
        PWR_LOCKOUT  = 7'h20,
        PWR_LEAVING  = 7'h40
    } pulk_pwr_state_t;

endpackage

// ==== src/pulk_delay_counter.sv ====
// Delay counter: done rises on the COUNT-th edge of continuous run, clears when run drops
`timescale 1ns/1ps
module pulk_delay_counter #(
    parameter int COUNT = 8000
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Control
    input  wire logic run,
    output logic      done
);
    localparam int W = $clog2(COUNT + 1);

    generate
        if (COUNT < 1) begin : g_bad_count
            $error("pulk_delay_counter: COUNT must be at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } pulk_cnt_state_t;

    pulk_cnt_state_t st_r;
    pulk_cnt_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!run) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt != W'(COUNT)) begin
            st_nxt.cnt = st_r.cnt + W'(1);
        end
        st_nxt.done = (st_nxt.cnt == W'(COUNT));
    end

    // Cleared by reset so no delay carries over a power cycle (see R21)
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done = st_r.done;

endmodule // pulk_delay_counter

// ==== src/pulk_sequencer.sv ====
// Power-on reset, undervoltage lockout and register lock sequencer
`timescale 1ns/1ps
module pulk_sequencer #(
    parameter int                          RELEASE_CYC = pulk_pkg::RESET_RELEASE_CYC,
    parameter int                          ENGAGE_CYC  = pulk_pkg::LOCKOUT_ENGAGE_CYC,
    parameter int                          WINDOW_CYC  = pulk_pkg::UNLOCK_WINDOW_CYC,
    parameter logic [pulk_pkg::CODE_W-1:0] UNLOCK_CODE = pulk_pkg::UNLOCK_CODE_DEFAULT
) (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // Supply comparators, asynchronous, high while supply is above the threshold
    input  wire logic                          reset_rise_threshold,
    input  wire logic                          reset_fall_threshold,
    input  wire logic                          lockout_exit_threshold,
    input  wire logic                          lockout_entry_threshold,
    // Stored permanent lock, level from nonvolatile memory
    input  wire logic                          permanent_lock_bit,
    // Register requests from the serial decoder
    input  wire logic                          req_valid,
    input  wire logic                          req_write,
    input  wire logic [pulk_pkg::ADDR_W-1:0]   req_addr,
    input  wire logic [pulk_pkg::CODE_W-1:0]   req_wdata,
    // Answers and status
    output logic                               req_grant,
    output logic                               req_refuse,
    output logic                               mem_access_open,
    output logic                               unlock_window_open,
    output logic                               permanent_lock_active,
    // Reset and output stage
    output logic                               internal_reset,
    output logic                               sensor_output_en,
    output logic                               sensor_output_gnd,
    output logic                               sensor_output_valid
);

    generate
        if (RELEASE_CYC < 1 || ENGAGE_CYC < 1 || WINDOW_CYC < 1) begin : g_bad_timing
            $error("pulk_sequencer: delay counts must be at least 1");
        end
    endgenerate

    // ==========================================================================
    // State
    typedef struct packed {
        logic [pulk_pkg::CMP_N-1:0] sync1;
        logic [pulk_pkg::CMP_N-1:0] sync2;
        pulk_pkg::pulk_pwr_state_t  pwr;
        logic                       int_reset;
        logic                       out_en;
        logic                       out_gnd;
        logic                       out_valid;
        logic                       perm;
        logic                       unlocked;
        logic                       window_over;
        logic                       win_open;
        logic                       grant;
        logic                       refuse;
    } pulk_top_state_t;

    pulk_top_state_t st_r;
    pulk_top_state_t st_nxt;

    logic rise_s;
    logic fall_s;
    logic exit_s;
    logic entry_s;
    logic rel_done;
    logic eng_done;
    logic dis_done;
    logic win_done;
    logic code_hit;

    // Only the second stage is read; the first stage may be metastable (see R21)
    assign rise_s  = st_r.sync2[pulk_pkg::CMP_RISE];
    assign fall_s  = st_r.sync2[pulk_pkg::CMP_FALL];
    assign exit_s  = st_r.sync2[pulk_pkg::CMP_EXIT];
    assign entry_s = st_r.sync2[pulk_pkg::CMP_ENTRY];

    assign code_hit = req_valid && req_write
                   && (req_addr == pulk_pkg::UNLOCK_CODE_ENTRY_ADDR);

    // ==========================================================================
    // Delay counters
    pulk_delay_counter #(.COUNT(RELEASE_CYC)) u_release (    // see (R17)
        .clock (clock),
        .rst   (rst),
        .run   (st_r.pwr == pulk_pkg::PWR_RELEASE),
        .done  (rel_done)
    );

    pulk_delay_counter #(.COUNT(ENGAGE_CYC)) u_engage (      // see (R18)
        .clock (clock),
        .rst   (rst),
        .run   (st_r.pwr == pulk_pkg::PWR_ENGAGING),
        .done  (eng_done)
    );

    // Shared by output arming after reset release and lockout exit; the two states never overlap
    pulk_delay_counter #(.COUNT(pulk_pkg::LOCKOUT_DISENGAGE_CYC)) u_disengage ( // see (R19)
        .clock (clock),
        .rst   (rst),
        .run   ((st_r.pwr == pulk_pkg::PWR_ARMING) || (st_r.pwr == pulk_pkg::PWR_LEAVING)),
        .done  (dis_done)
    );

    // Only power-off rearms the window
    pulk_delay_counter #(.COUNT(WINDOW_CYC)) u_window (      // see (R11)
        .clock (clock),
        .rst   (rst),
        .run   ((st_r.pwr != pulk_pkg::PWR_OFF) && !st_r.window_over),
        .done  (win_done)
    );

    // ==========================================================================
    // Next state
    always_comb begin
        st_nxt        = st_r;
        st_nxt.sync1  = {lockout_entry_threshold, lockout_exit_threshold,
                         reset_fall_threshold, reset_rise_threshold};
        st_nxt.sync2  = st_r.sync1;
        st_nxt.grant  = 1'b0;
        st_nxt.refuse = 1'b0;

        case (st_r.pwr)
            pulk_pkg::PWR_OFF: begin
                if (rise_s) begin
                    st_nxt.pwr  = pulk_pkg::PWR_RELEASE;              // see (R2)
                    // Lock bit only takes effect from the following power-up
                    st_nxt.perm = permanent_lock_bit;                 // see (R13)
                end
            end
            pulk_pkg::PWR_RELEASE: begin
                if (rel_done && exit_s) begin
                    st_nxt.pwr = pulk_pkg::PWR_ARMING;                // see (R3)
                end
            end
            pulk_pkg::PWR_ARMING: begin
                if (dis_done) begin
                    st_nxt.pwr = pulk_pkg::PWR_RUN;
                end
            end
            pulk_pkg::PWR_RUN: begin
                if (!entry_s) begin
                    st_nxt.pwr = pulk_pkg::PWR_ENGAGING;
                end
            end
            pulk_pkg::PWR_ENGAGING: begin
                if (entry_s) begin
                    st_nxt.pwr = pulk_pkg::PWR_RUN;                   // see (R18)
                end else if (eng_done) begin
                    st_nxt.pwr = pulk_pkg::PWR_LOCKOUT;               // see (R5) (R7)
                end
            end
            pulk_pkg::PWR_LOCKOUT: begin
                if (exit_s) begin
                    st_nxt.pwr = pulk_pkg::PWR_LEAVING;               // see (R6)
                end
            end
            pulk_pkg::PWR_LEAVING: begin
                if (!exit_s) begin
                    st_nxt.pwr = pulk_pkg::PWR_LOCKOUT;
                end else if (dis_done) begin
                    st_nxt.pwr = pulk_pkg::PWR_RUN;                   // see (R8)
                end
            end
            default: begin
                st_nxt.pwr = pulk_pkg::PWR_OFF;
            end
        endcase

        // Falling below the reset fall level beats every other transition
        if ((st_r.pwr != pulk_pkg::PWR_OFF) && !fall_s) begin
            st_nxt.pwr = pulk_pkg::PWR_OFF;                           // see (R4)
        end

        // Window expiry is sticky for the rest of the session
        if (win_done) begin
            st_nxt.window_over = 1'b1;                                // see (R20)
        end

        // Register requests
        if (req_valid) begin
            if (st_r.perm || st_r.int_reset) begin
                st_nxt.refuse = 1'b1;                                 // see (R13) (R14) (R15)
            end else if (code_hit) begin
                if ((req_wdata == UNLOCK_CODE) && !st_r.window_over) begin
                    st_nxt.unlocked = 1'b1;                           // see (R10) (R11)
                    st_nxt.grant    = 1'b1;
                end else begin
                    st_nxt.refuse = 1'b1;
                end
            end else if (st_r.unlocked) begin
                st_nxt.grant = 1'b1;
            end else begin
                st_nxt.refuse = 1'b1;                                 // see (R9) (R20)
            end
        end

        // A power cycle wipes the session, including an unlock taken this cycle
        if (st_nxt.pwr == pulk_pkg::PWR_OFF) begin
            st_nxt.unlocked    = 1'b0;                                // see (R12)
            st_nxt.window_over = 1'b0;
        end

        st_nxt.int_reset = (st_nxt.pwr == pulk_pkg::PWR_OFF)
                        || (st_nxt.pwr == pulk_pkg::PWR_RELEASE);     // see (R1) (R3)
        st_nxt.out_en    = !(st_nxt.int_reset || (st_nxt.pwr == pulk_pkg::PWR_ARMING));
        st_nxt.out_gnd   = (st_nxt.pwr == pulk_pkg::PWR_LOCKOUT)
                        || (st_nxt.pwr == pulk_pkg::PWR_LEAVING);     // see (R5)
        st_nxt.out_valid = (st_nxt.pwr == pulk_pkg::PWR_RUN)
                        || (st_nxt.pwr == pulk_pkg::PWR_ENGAGING);
        st_nxt.win_open  = (st_nxt.pwr != pulk_pkg::PWR_OFF) && !st_nxt.window_over;
    end

    // ==========================================================================
    // Registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r           <= '0;
            st_r.sync1     <= pulk_pkg::CMP_RESET_VAL;
            st_r.sync2     <= pulk_pkg::CMP_RESET_VAL;
            st_r.pwr       <= pulk_pkg::PWR_OFF;                      // see (R1)
            st_r.int_reset <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign req_grant             = st_r.grant;
    assign req_refuse            = st_r.refuse;
    assign mem_access_open       = st_r.unlocked;
    assign unlock_window_open    = st_r.win_open;
    assign permanent_lock_active = st_r.perm;
    assign internal_reset        = st_r.int_reset;
    assign sensor_output_en      = st_r.out_en;
    assign sensor_output_gnd     = st_r.out_gnd;
    assign sensor_output_valid   = st_r.out_valid;

    // ==========================================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_reset_hiz_out: assert property (                                // see (R1)
        st_r.int_reset |-> !st_r.out_en && !st_r.out_valid)
        else $error("output driven during internal reset");

    a_release_start_rise: assert property (                           // see (R2)
        (st_r.pwr == pulk_pkg::PWR_OFF) ##1 (st_r.pwr == pulk_pkg::PWR_RELEASE)
        |-> $past(rise_s))
        else $error("release counter started without rise crossing");

    a_reset_release_both: assert property (                           // see (R3)
        $fell(st_r.int_reset) |-> $past(rel_done) && $past(exit_s))
        else $error("reset released early");

    a_fall_reasserts: assert property (                               // see (R4)
        (st_r.pwr != pulk_pkg::PWR_OFF) && !fall_s
        |=> st_r.int_reset && !st_r.out_en && !mem_access_open)
        else $error("fall crossing did not reassert reset");

    a_engage_after_delay: assert property (                           // see (R7)
        $rose(st_r.out_gnd) |-> $past(eng_done) && $past(!entry_s))
        else $error("lockout engaged before delay");

    a_engage_cancel: assert property (                                // see (R18)
        (st_r.pwr == pulk_pkg::PWR_ENGAGING) && entry_s && fall_s
        |=> st_r.out_valid && !st_r.out_gnd)
        else $error("recovered supply still engaged lockout");

    a_lockout_leave: assert property (                                // see (R8)
        $fell(st_r.out_gnd) && st_r.out_valid |-> $past(dis_done) && $past(exit_s))
        else $error("lockout released without disengage delay");

    a_power_cycle_lock: assert property (                             // see (R12)
        (st_r.pwr == pulk_pkg::PWR_OFF) |-> !mem_access_open)
        else $error("unlock survived a power cycle");

    a_perm_refuse: assert property (                                  // see (R13)
        st_r.perm && req_valid |=> req_refuse && !req_grant)
        else $error("access granted under permanent lock");

    a_perm_no_unlock: assert property (                               // see (R14)
        st_r.perm |-> !mem_access_open)
        else $error("unlocked under permanent lock");

    a_code_unlocks: assert property (                                 // see (R10)
        code_hit && (req_wdata == UNLOCK_CODE) && st_r.win_open
        && !st_r.perm && !st_r.int_reset && fall_s
        |=> mem_access_open && req_grant)
        else $error("valid code did not unlock");

    a_late_code_refused: assert property (                            // see (R20)
        req_valid && st_r.window_over && !st_r.unlocked |=> req_refuse ##1 !mem_access_open)
        else $error("access after window expiry");

    c_unlock: cover property ($rose(mem_access_open));
    c_lockout: cover property ($fell(st_r.out_gnd) && st_r.out_valid);
    c_window_expiry: cover property ($fell(st_r.win_open) && !mem_access_open);
    c_engage_cancel: cover property ((st_r.pwr == pulk_pkg::PWR_ENGAGING)
                                     ##1 (st_r.pwr == pulk_pkg::PWR_RUN));

endmodule // pulk_sequencer

// ==== sim/pulk_supply_model.sv ====
// Supply rail model: turns a coarse supply level into the four comparator flags
`timescale 1ns/1ps
module pulk_supply_model (
    // Clock
    input  wire logic       clock,
    // Supply level: 0 off, 1 above reset levels, 2 above lockout entry, 3 above lockout exit
    input  wire logic [1:0] supply_level,
    // Comparator flags, high while the supply is above the level
    output logic            reset_rise_threshold,
    output logic            reset_fall_threshold,
    output logic            lockout_exit_threshold,
    output logic            lockout_entry_threshold
);
    // ==========================================================================
    // Comparators
    // Flags move a little after the edge, like a real asynchronous comparator would
    logic [1:0] level_r = 2'h0;

    always @(posedge clock) begin
        level_r <= #2 supply_level;
    end

    assign reset_rise_threshold    = (level_r >= 2'h1);
    assign reset_fall_threshold    = (level_r >= 2'h1);
    assign lockout_entry_threshold = (level_r >= 2'h2);
    assign lockout_exit_threshold  = (level_r == 2'h3);
endmodule // pulk_supply_model

// ==== sim/pulk_sequencer_bench.sv ====
// Self-checking bench for the power sequencer and register lock
`timescale 1ns/1ps
`define CHECK(name, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got); \
        end \
    end
module pulk_sequencer_bench;
    // ==========================================================================
    // Settings
    // Short counts keep the run brief; the disengage delay is fixed in the design
    localparam int REL_CYC = 20;
    localparam int ENG_CYC = 20;
    localparam int WIN_CYC = 200;
    localparam int DIS_CYC = pulk_pkg::LOCKOUT_DISENGAGE_CYC;
    localparam logic [pulk_pkg::CODE_W-1:0] CODE = 30'h2B5A_5C3D;
    localparam logic [pulk_pkg::ADDR_W-1:0] ADDR = pulk_pkg::UNLOCK_CODE_ENTRY_ADDR;
    localparam int W_RST   = 0;
    localparam int W_VALID = 1;
    localparam int W_GND   = 2;
    localparam int W_WIN   = 3;

    logic                          clock;
    logic                          rst;
    logic [1:0]                    supply_level;
    logic                          reset_rise_threshold;
    logic                          reset_fall_threshold;
    logic                          lockout_exit_threshold;
    logic                          lockout_entry_threshold;
    logic                          permanent_lock_bit;
    logic                          req_valid;
    logic                          req_write;
    logic [pulk_pkg::ADDR_W-1:0]   req_addr;
    logic [pulk_pkg::CODE_W-1:0]   req_wdata;
    logic                          req_grant;
    logic                          req_refuse;
    logic                          mem_access_open;
    logic                          unlock_window_open;
    logic                          permanent_lock_active;
    logic                          internal_reset;
    logic                          sensor_output_en;
    logic                          sensor_output_gnd;
    logic                          sensor_output_valid;
    int                            errors;
    int                            n_compared;
    int                            cyc = 0;
    int                            t0;

    // ==========================================================================
    // Clock, instances and watchdog
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
    end

    pulk_sequencer #(.RELEASE_CYC(REL_CYC), .ENGAGE_CYC(ENG_CYC), .WINDOW_CYC(WIN_CYC),
        .UNLOCK_CODE(CODE)) i_pulk_sequencer (
        .clock(clock), .rst(rst),
        .reset_rise_threshold(reset_rise_threshold),
        .reset_fall_threshold(reset_fall_threshold),
        .lockout_exit_threshold(lockout_exit_threshold),
        .lockout_entry_threshold(lockout_entry_threshold),
        .permanent_lock_bit(permanent_lock_bit),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_grant(req_grant), .req_refuse(req_refuse),
        .mem_access_open(mem_access_open), .unlock_window_open(unlock_window_open),
        .permanent_lock_active(permanent_lock_active), .internal_reset(internal_reset),
        .sensor_output_en(sensor_output_en), .sensor_output_gnd(sensor_output_gnd),
        .sensor_output_valid(sensor_output_valid));

    pulk_supply_model i_pulk_supply_model (
        .clock(clock), .supply_level(supply_level),
        .reset_rise_threshold(reset_rise_threshold),
        .reset_fall_threshold(reset_fall_threshold),
        .lockout_exit_threshold(lockout_exit_threshold),
        .lockout_entry_threshold(lockout_entry_threshold));

    // Whole run needs about 3900 cycles
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        $display("[FAIL] watchdog expired before the tests ended");
        finish_test();
    end

    // ==========================================================================
    // Tasks
    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    // One-cycle request; the one-cycle answer is looked at just after the taking edge
    task automatic request(input logic wr, input logic [pulk_pkg::ADDR_W-1:0] addr,
                           input logic [pulk_pkg::CODE_W-1:0] data, input logic ok);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = addr;
        req_wdata = data;
        step(1);
        `CHECK("req_grant", ok, req_grant)
        `CHECK("req_refuse", ~ok, req_refuse)
        req_valid = 1'b0;
        step(1);
    endtask

    function automatic logic watch(input int sel);
        case (sel)
            W_RST:   return internal_reset;
            W_VALID: return sensor_output_valid;
            W_GND:   return sensor_output_gnd;
            default: return unlock_window_open;
        endcase
    endfunction

    task automatic count_until(input int sel, input logic val, input int lim);
        int k;
        k = 0;
        while (watch(sel) !== val && k < lim) begin
            step(1);
            k++;
        end
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================================
    // Tests
    initial begin
        errors = 0;
        n_compared = 0;
        rst = 1'b1;
        supply_level = 2'h0;
        permanent_lock_bit = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        step(10);
        `CHECK("reset held", 1'b1, internal_reset)
        `CHECK("output hi-z", 1'b0, sensor_output_en)
        rst = 1'b0;
        step(5);
        request(1'b1, ADDR, CODE, 1'b0);
        // Supply stalls between the reset and lockout exit levels
        supply_level = 2'h2;
        step(60);
        `CHECK("reset waits for exit", 1'b1, internal_reset)
        `CHECK("hi-z before exit", 1'b0, sensor_output_en)
        t0 = cyc;
        supply_level = 2'h3;
        count_until(W_RST, 1'b0, 20);
        `CHECK("release at exit", 1'b1, cyc - t0 <= 6)
        request(1'b0, ADDR, '0, 1'b0);
        request(1'b1, ADDR, CODE ^ 30'h0000_0001, 1'b0);
        request(1'b1, ADDR + 8'h01, CODE, 1'b0);
        request(1'b1, ADDR, CODE, 1'b1);
        `CHECK("access open", 1'b1, mem_access_open)
        request(1'b0, ADDR, '0, 1'b1);
        // Sensitivity trim first, then zero-field level trim
        request(1'b1, 8'h01, '0, 1'b1);
        request(1'b1, 8'h02, '0, 1'b1);
        count_until(W_VALID, 1'b1, 2000);
        `CHECK("first disengage", 1'b1, cyc - t0 >= DIS_CYC && cyc - t0 <= DIS_CYC + 8)
        `CHECK("output driven", 1'b1, sensor_output_en)
        // A dip shorter than the engage count must be ignored
        supply_level = 2'h1;
        step(ENG_CYC - 6);
        supply_level = 2'h3;
        count_until(W_GND, 1'b1, 40);
        `CHECK("short dip ignored", 1'b0, sensor_output_gnd)
        `CHECK("still valid", 1'b1, sensor_output_valid)
        t0 = cyc;
        supply_level = 2'h1;
        count_until(W_GND, 1'b1, 60);
        `CHECK("engage delay", 1'b1, cyc - t0 >= ENG_CYC && cyc - t0 <= ENG_CYC + 6)
        `CHECK("not valid in lockout", 1'b0, sensor_output_valid)
        `CHECK("driven in lockout", 1'b1, sensor_output_en)
        t0 = cyc;
        supply_level = 2'h3;
        count_until(W_VALID, 1'b1, 2000);
        `CHECK("disengage delay", 1'b1, cyc - t0 >= DIS_CYC && cyc - t0 <= DIS_CYC + 6)
        `CHECK("ground released", 1'b0, sensor_output_gnd)
        supply_level = 2'h0;
        count_until(W_RST, 1'b1, 10);
        `CHECK("reset on power-down", 1'b1, internal_reset)
        `CHECK("hi-z on power-down", 1'b0, sensor_output_en)
        `CHECK("unlock discarded", 1'b0, mem_access_open)
        step(5);
        t0 = cyc;
        supply_level = 2'h3;
        count_until(W_RST, 1'b0, 60);
        `CHECK("release time", 1'b1, cyc - t0 >= REL_CYC && cyc - t0 <= REL_CYC + 8)
        request(1'b0, ADDR, '0, 1'b0);
        count_until(W_WIN, 1'b0, 400);
        `CHECK("window length", 1'b1, cyc - t0 >= WIN_CYC && cyc - t0 <= WIN_CYC + 8)
        request(1'b1, ADDR, CODE, 1'b0);
        `CHECK("locked after window", 1'b0, mem_access_open)
        // Permanent lock only acts after a power cycle
        supply_level = 2'h0;
        permanent_lock_bit = 1'b1;
        step(8);
        supply_level = 2'h3;
        count_until(W_RST, 1'b0, 60);
        `CHECK("lock sampled", 1'b1, permanent_lock_active)
        `CHECK("window running", 1'b1, unlock_window_open)
        request(1'b1, ADDR, CODE, 1'b0);
        request(1'b0, ADDR, '0, 1'b0);
        request(1'b1, 8'h00, '0, 1'b0);
        `CHECK("no access", 1'b0, mem_access_open)
        finish_test();
    end
endmodule // pulk_sequencer_bench
